// ==== tb/debug_command_decoder_chk.sv ====
// Checker for the serial debug command decoder, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
module debug_command_decoder_chk (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CPU_HALT,
   input wire logic CPU_STEP,
   input wire logic PC_CLEAR,
   input wire logic MODULE_RESET,
   input wire logic CPU_PORT_BUSY,
   input wire logic PORT_WR,
   input wire logic PORT_RD,
   input wire logic FLASH_PROGRAM,
   input wire logic FLASH_READ,
   input wire logic FLASH_PAGE_ERASE,
   input wire logic FLASH_PART_ERASE,
   input wire logic [debug_decoder_pkg::FLASH_ADDR_BITS-1:0] FLASH_ADDR,
   input wire logic AUX_PARTITION_SEL
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   property p_port_prio;
      CPU_PORT_BUSY |-> !PORT_WR && !PORT_RD;
   endproperty
   a_port_prio: assert property (p_port_prio) else $error("port access while CPU holds bus");
   property p_step_pulse;
      CPU_STEP |=> !CPU_STEP;
   endproperty
   a_step_pulse: assert property (p_step_pulse) else $error("step longer than one cycle");
   property p_step_halted;
      CPU_STEP |-> CPU_HALT && $past(CPU_HALT);
   endproperty
   a_step_halted: assert property (p_step_halted) else $error("step while running");
   property p_flash_halted;
      FLASH_PROGRAM || FLASH_READ || FLASH_PAGE_ERASE || FLASH_PART_ERASE |-> CPU_HALT;
   endproperty
   a_flash_halted: assert property (p_flash_halted) else $error("flash access while running");
   property p_page_align;
      FLASH_PAGE_ERASE |-> FLASH_ADDR[5:0] == 6'h00;
   endproperty
   a_page_align: assert property (p_page_align) else $error("page erase address not aligned");
   property p_halt_aux;
      $rose(CPU_HALT) |-> !AUX_PARTITION_SEL;
   endproperty
   a_halt_aux: assert property (p_halt_aux) else $error("halt kept auxiliary partition");
   property p_aux_halted;
      $rose(AUX_PARTITION_SEL) |-> CPU_HALT;
   endproperty
   a_aux_halted: assert property (p_aux_halted) else $error("partition switch while running");
   property p_clear_halted;
      PC_CLEAR |-> CPU_HALT ##1 !PC_CLEAR;
   endproperty
   a_clear_halted: assert property (p_clear_halted) else $error("counter clear misplaced");
   property p_mreset_halted;
      MODULE_RESET |-> CPU_HALT ##1 !MODULE_RESET;
   endproperty
   a_mreset_halted: assert property (p_mreset_halted) else $error("module reset misplaced");
endmodule // debug_command_decoder_chk

bind debug_command_decoder debug_command_decoder_chk checker_inst (.*);

// ==== tb/host_link_model.sv ====
// Host side of the serial debug link: sends frames of an address nibble and a value nibble.
// Assumes the bench calls send; the link clock stands still between frames.
module host_link_model (
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_OE,
   output logic SELECT_N,
   output logic LINK_CLOCK,
   output logic SERIAL_IN_LINE
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      SELECT_N = 1'b1;
      LINK_CLOCK = 1'b0;
      SERIAL_IN_LINE = 1'b1;
   end
   task automatic send(input logic [3:0] a, input logic [3:0] v);
      logic [7:0] f;
      f = {v, a};
      SELECT_N <= 1'b0;
      #100;
      for (int i = 0; i < 8; i++) begin
         SERIAL_IN_LINE <= f[i];
         #80 LINK_CLOCK <= 1'b1;
         #80 LINK_CLOCK <= 1'b0;
      end
      #100;
      SELECT_N <= 1'b1;
      // The released line shows the inverse, so a stale bit cannot pass for data.
      SERIAL_IN_LINE <= ~SERIAL_IN_LINE;
      #300;
   endtask
   // Readout frame: address 1111, then the word is taken just before each later rising edge.
   // The output enable is seen once in the address phase and once during the shift.
   task automatic read_word(output logic [15:0] w, output logic [1:0] oe);
      w = '0;
      oe = '0;
      SELECT_N <= 1'b0;
      SERIAL_IN_LINE <= 1'b1;
      #100;
      for (int i = 0; i < 20; i++) begin
         #80;
         if (i == 1) oe[0] = SERIAL_OUT_OE;
         if (i == 4) oe[1] = SERIAL_OUT_OE;
         if (i >= 4) w[i - 4] = SERIAL_OUT;
         LINK_CLOCK <= 1'b1;
         #80 LINK_CLOCK <= 1'b0;
      end
      #100;
      SELECT_N <= 1'b1;
      SERIAL_IN_LINE <= 1'b0;
      #300;
   endtask
endmodule // host_link_model

// ==== tb/serial_debug_command_decoder_tb.sv ====
// Self-checking bench for the serial debug command decoder.
// Assumes the host link model for framing and a flash that answers three cycles after a request.
module serial_debug_command_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic MCLK, RESETN, SELECT_N, LINK_CLOCK, SERIAL_IN_LINE, SERIAL_OUT, SERIAL_OUT_OE, BUSY;
   logic CPU_HALT, CPU_STEP, PC_CLEAR, MODULE_RESET, CPU_PORT_BUSY, PORT_WR, PORT_RD, THREE_WIRE;
   logic FLASH_PROGRAM, FLASH_READ, FLASH_PAGE_ERASE, FLASH_PART_ERASE, FLASH_DONE, AUX_PARTITION_SEL;
   logic [15:0] CPU_ACC, CPU_PC, PORT_WDATA, PORT_RDATA;
   logic [3:0] PORT_SEL;
   logic [11:0] FLASH_ADDR;
   logic [7:0] FLASH_WDATA, FLASH_RDATA;
   logic [2:0] fl_wait = 3'h0;
   int n[5];
   int s[5];
   int error_cnt = 0;
   int samples_checked = 0;
   debug_command_decoder DUT (.*);
   host_link_model host (.SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE), .SELECT_N(SELECT_N),
                         .LINK_CLOCK(LINK_CLOCK), .SERIAL_IN_LINE(SERIAL_IN_LINE));
   initial begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end
   // Pulses are counted so that a doubled or missing one shows.
   always @(posedge MCLK) begin
      FLASH_DONE <= 1'b0;
      if (FLASH_PROGRAM | FLASH_READ | FLASH_PAGE_ERASE | FLASH_PART_ERASE) begin
         fl_wait <= 3'h3;
      end else if (fl_wait != 3'h0) begin
         fl_wait <= fl_wait - 3'h1;
         FLASH_DONE <= (fl_wait == 3'h1);
      end
      n[0] <= n[0] + int'(CPU_STEP);
      n[1] <= n[1] + int'(PC_CLEAR);
      n[2] <= n[2] + int'(MODULE_RESET);
      n[3] <= n[3] + int'(PORT_WR);
      n[4] <= n[4] + int'(FLASH_PROGRAM | FLASH_READ | FLASH_PAGE_ERASE | FLASH_PART_ERASE);
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmd(input logic [3:0] c);
      host.send(4'h8, c);
      repeat (10) @(posedge MCLK);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic t_nibbles;
      logic [15:0] a = 16'h0FC5;
      logic [15:0] w;
      logic [1:0] oe;
      for (int i = 0; i < 4; i++) host.send(4'(i), 4'(i + 1));
      chk("holding", 16'h4321, PORT_WDATA);
      for (int i = 0; i < 4; i++) host.send(4'(4 + i), a[4*i+:4]);
      chk("port_sel", 16'h0005, {12'h000, PORT_SEL});
      for (int i = 10; i < 15; i++) host.send(4'(i), 4'hF);
      chk("holding", 16'h4321, PORT_WDATA);
      chk("port_sel", 16'h0005, {12'h000, PORT_SEL});
      host.send(4'h9, 4'h1);
      chk("three_wire", 16'h0001, {15'h0, THREE_WIRE});
      host.read_word(w, oe);
      chk("readout", 16'h4321, w);
      chk("oe", 16'h0002, {14'h0, oe});
      host.send(4'h9, 4'h0);
      chk("three_wire", 16'h0000, {15'h0, THREE_WIRE});
      host.read_word(w, oe);
      chk("oe", 16'h0003, {14'h0, oe});
      $display("nibble test done");
   endtask
   task automatic t_port;
      s = n;
      cmd(4'h0);
      chk("port_writes", 16'h0000, 16'(n[3] - s[3]));
      chk("busy", 16'h0001, {15'h0, BUSY});
      @(posedge MCLK);
      CPU_PORT_BUSY <= 1'b0;
      repeat (3) @(posedge MCLK);
      chk("port_writes", 16'h0001, 16'(n[3] - s[3]));
      chk("busy", 16'h0000, {15'h0, BUSY});
      cmd(4'h2);
      chk("holding", 16'hBEEF, PORT_WDATA);
      cmd(4'h4);
      chk("holding", 16'hBEEF, PORT_WDATA);
      $display("port test done");
   endtask
   task automatic t_halt;
      cmd(4'h7);
      chk("halt", 16'h0001, {15'h0, CPU_HALT});
      cmd(4'h4);
      chk("holding", 16'h1234, PORT_WDATA);
      cmd(4'h6);
      chk("holding", 16'h0456, PORT_WDATA);
      cmd(4'h5);
      chk("holding", 16'h04A5, PORT_WDATA);
      chk("flash_addr", 16'h0456, {4'h0, FLASH_ADDR});
      host.send(4'h0, 4'h0);
      cmd(4'h3);
      chk("holding", 16'h04A5, PORT_WDATA);
      chk("flash_addr", 16'h0FC5, {4'h0, FLASH_ADDR});
      s = n;
      cmd(4'h9);
      chk("steps", 16'h0001, 16'(n[0] - s[0]));
      cmd(4'hA);
      chk("pc_clears", 16'h0001, 16'(n[1] - s[1]));
      cmd(4'hB);
      chk("module_resets", 16'h0001, 16'(n[2] - s[2]));
      cmd(4'hC);
      chk("holding", 16'h04A5, PORT_WDATA);
      cmd(4'hD);
      chk("flash_addr", 16'h0FC0, {4'h0, FLASH_ADDR});
      cmd(4'hE);
      cmd(4'h1);
      chk("flash_wdata", 16'h00A5, {8'h00, FLASH_WDATA});
      chk("flash_requests", 16'h0003, 16'(n[4] - s[4]));
      cmd(4'hF);
      chk("aux", 16'h0001, {15'h0, AUX_PARTITION_SEL});
      cmd(4'h7);
      chk("aux", 16'h0000, {15'h0, AUX_PARTITION_SEL});
      cmd(4'h8);
      chk("halt", 16'h0000, {15'h0, CPU_HALT});
      s = n;
      cmd(4'h9);
      chk("steps", 16'h0000, 16'(n[0] - s[0]));
      $display("halt test done");
   endtask
   initial begin
      RESETN = 1'b0;
      CPU_PORT_BUSY = 1'b1;
      CPU_ACC = 16'h1234;
      CPU_PC = 16'h0456;
      PORT_RDATA = 16'hBEEF;
      FLASH_RDATA = 8'hA5;
      repeat (10) @(posedge MCLK);
      RESETN <= 1'b1;
      repeat (5) @(posedge MCLK);
      t_nibbles;
      t_port;
      t_halt;
      final_report;
   end
   initial begin
      #200000;
      error_cnt++;
      final_report;
   end
endmodule // serial_debug_command_decoder_tb

// ==== verilog/debug_command_decoder.sv ====
// Serial debug command decoder: nibble registers and the command executor facing CPU and flash.
// Assumes a CPU with a halt input and a port bus, and a flash controller with a done handshake.
// Overview of operation
// - Addresses 0000-0011 write the nibble into holding bits 3:0 up to 15:12.
// - Addresses 0100-0111 write successive address-register nibbles, lowest first.
// - Address 1000 loads the command register and launches that command.
// - Address 1001 loads the interface wiring mode register.
// - Command 0000 writes the holding word to the port chosen by address bits 3:0.
// - Command 0001 programs holding low byte into flash at address bits 11:0; halted only.
// - Command 0010 reads the selected port into holding, even while the CPU runs.
// - Command 0011 reads flash at address bits 11:0 into holding low byte; halted only.
// - Command 0100 copies the accumulator into holding; halted only.
// - Command 0101 reads the flash byte at the program counter into holding low byte; halted only.
// - Command 0110 copies the program counter into holding; halted only.
// - Command 0111 halts the CPU always; command 1000 clears the halt.
// - Command 1001 while halted lets the CPU run exactly one clock.
// - Command 1010 while halted zeroes the program counter.
// - Command 1011 while halted resets modules, flash controller and registers D-F.
// - Command 1101 erases the 64-byte flash page at address bits 11:6; halted only.
// - Command 1110 erases the whole selected flash partition; halted only.
// - Command 1111 while halted selects the auxiliary partition; the next halt restores the main one.
// - On simultaneous port access the CPU goes first.
// - Mode 0000 is 4-wire, 0001 is 3-wire; other values are unused.
module debug_command_decoder
   import debug_decoder_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic SELECT_N,
   input wire logic LINK_CLOCK,
   input wire logic SERIAL_IN_LINE,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_OE,
   output logic CPU_HALT,
   output logic CPU_STEP,
   output logic PC_CLEAR,
   output logic MODULE_RESET,
   input wire logic [debug_decoder_pkg::WORD_BITS-1:0] CPU_ACC,
   input wire logic [debug_decoder_pkg::WORD_BITS-1:0] CPU_PC,
   input wire logic CPU_PORT_BUSY,
   output logic [debug_decoder_pkg::PORT_SEL_BITS-1:0] PORT_SEL,
   output logic [debug_decoder_pkg::WORD_BITS-1:0] PORT_WDATA,
   output logic PORT_WR,
   output logic PORT_RD,
   input wire logic [debug_decoder_pkg::WORD_BITS-1:0] PORT_RDATA,
   output logic [debug_decoder_pkg::FLASH_ADDR_BITS-1:0] FLASH_ADDR,
   output logic [debug_decoder_pkg::BYTE_BITS-1:0] FLASH_WDATA,
   output logic FLASH_PROGRAM,
   output logic FLASH_READ,
   output logic FLASH_PAGE_ERASE,
   output logic FLASH_PART_ERASE,
   input wire logic FLASH_DONE,
   input wire logic [debug_decoder_pkg::BYTE_BITS-1:0] FLASH_RDATA,
   output logic AUX_PARTITION_SEL,
   output logic THREE_WIRE,
   output logic BUSY
);
   import debug_decoder_pkg::*;

   logic sel_level, sclk_rise, sclk_fall, sdi_level;
   logic [WORD_BITS-1:0] data_holding_reg;
   logic [WORD_BITS-1:0] port_flash_address_reg;
   logic [3:0] command_code_reg;
   logic [3:0] interface_wiring_mode_reg;
   logic start_reg;
   logic halt_reg;
   logic aux_reg;
   logic flash_capture_reg;
   exec_state_type state_reg;
   command_type cmd;

   nibble_link_if link ();

   pin_sampler select_sampler (
      .clk(MCLK),
      .rst_n(RESETN),
      .pin(!SELECT_N),
      .level(sel_level),
      .rise(),
      .fall()
   );

   pin_sampler clock_sampler (
      .clk(MCLK),
      .rst_n(RESETN),
      .pin(LINK_CLOCK),
      .level(),
      .rise(sclk_rise),
      .fall(sclk_fall)
   );

   pin_sampler data_sampler (
      .clk(MCLK),
      .rst_n(RESETN),
      .pin(SERIAL_IN_LINE),
      .level(sdi_level),
      .rise(),
      .fall()
   );

   frame_receiver receiver (
      .clk(MCLK),
      .rst_n(RESETN),
      .sel_active(sel_level),
      .sclk_rise(sclk_rise),
      .sclk_fall(sclk_fall),
      .sdi(sdi_level),
      .link(link.receiver),
      .sdo(SERIAL_OUT),
      .sdo_oe(SERIAL_OUT_OE)
   );

   // Replaces one nibble of a 16-bit word; used by both nibble-loaded registers.
   function automatic logic [WORD_BITS-1:0] put_nibble(input logic [WORD_BITS-1:0] word,
                                                      input logic [1:0] index,
                                                      input logic [3:0] value);
      logic [WORD_BITS-1:0] result;
      result = word;
      result[index * NIBBLE_BITS +: NIBBLE_BITS] = value;
      return result;
   endfunction

   function automatic logic in_range(input logic [3:0] a, input logic [3:0] lo, input logic [3:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   assign cmd = command_type'(command_code_reg);
   assign link.readout = data_holding_reg;
   assign link.four_wire = (interface_wiring_mode_reg != MODE_THREE_WIRE);
   assign THREE_WIRE = (interface_wiring_mode_reg == MODE_THREE_WIRE);
   assign CPU_HALT = halt_reg;
   assign AUX_PARTITION_SEL = aux_reg;
   assign BUSY = (state_reg != ST_IDLE) || start_reg;
   assign PORT_SEL = port_flash_address_reg[PORT_SEL_BITS-1:0];
   assign PORT_WDATA = data_holding_reg;

   // CPU port priority.
   // The serial side only touches the port bus in a cycle the CPU leaves free.
   assign PORT_WR = (state_reg == ST_PORT_WRITE) && !CPU_PORT_BUSY;
   assign PORT_RD = (state_reg == ST_PORT_READ) && !CPU_PORT_BUSY;

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         port_flash_address_reg <= ADDR_RESET;
      end else if (link.nib_wr && in_range(link.nib_addr, NIB_ADDR_LOW, NIB_ADDR_HIGH)) begin
         port_flash_address_reg <= put_nibble(port_flash_address_reg, link.nib_addr[1:0], link.nib_val);
      end
   end

   // Unused addresses fall through every decode.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         command_code_reg <= COMMAND_RESET;
         start_reg <= 1'b0;
      end else begin
         start_reg <= link.nib_wr && (link.nib_addr == NIB_COMMAND);
         if (link.nib_wr && link.nib_addr == NIB_COMMAND) begin
            command_code_reg <= link.nib_val;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         interface_wiring_mode_reg <= MODE_RESET;
      end else if (link.nib_wr && link.nib_addr == NIB_MODE) begin
         interface_wiring_mode_reg <= link.nib_val;
      end
   end

   // Halt state and partition selection.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         halt_reg <= HALT_RESET;
         aux_reg <= 1'b0;
      end else if (start_reg && state_reg == ST_IDLE) begin
         unique case (cmd)
            CMD_HALT: begin
               halt_reg <= 1'b1;
               aux_reg <= 1'b0;
            end
            CMD_START: begin
               halt_reg <= 1'b0;
            end
            CMD_AUX_PARTITION: begin
               if (halt_reg) begin
                  aux_reg <= 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // One-cycle CPU control pulses; each is refused while the CPU runs.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         CPU_STEP <= 1'b0;
         PC_CLEAR <= 1'b0;
         MODULE_RESET <= 1'b0;
      end else begin
         CPU_STEP <= start_reg && state_reg == ST_IDLE && halt_reg && cmd == CMD_STEP;
         PC_CLEAR <= start_reg && state_reg == ST_IDLE && halt_reg && cmd == CMD_PC_ZERO;
         MODULE_RESET <= start_reg && state_reg == ST_IDLE && halt_reg && cmd == CMD_MODULE_RESET;
      end
   end

   // Executor sequencing; flash requests are one-cycle pulses answered by FLASH_DONE.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_IDLE;
         flash_capture_reg <= 1'b0;
         FLASH_ADDR <= '0;
         FLASH_WDATA <= '0;
         FLASH_PROGRAM <= 1'b0;
         FLASH_READ <= 1'b0;
         FLASH_PAGE_ERASE <= 1'b0;
         FLASH_PART_ERASE <= 1'b0;
      end else begin
         FLASH_PROGRAM <= 1'b0;
         FLASH_READ <= 1'b0;
         FLASH_PAGE_ERASE <= 1'b0;
         FLASH_PART_ERASE <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               if (start_reg) begin
                  unique case (cmd)
                     CMD_PORT_WRITE: state_reg <= ST_PORT_WRITE;
                     CMD_PORT_READ: state_reg <= ST_PORT_READ;
                     CMD_FLASH_WRITE: begin
                        if (halt_reg) begin
                           FLASH_ADDR <= port_flash_address_reg[FLASH_ADDR_BITS-1:0];
                           FLASH_WDATA <= data_holding_reg[BYTE_BITS-1:0];
                           FLASH_PROGRAM <= 1'b1;
                           flash_capture_reg <= 1'b0;
                           state_reg <= ST_FLASH_WAIT;
                        end
                     end
                     CMD_FLASH_READ: begin
                        if (halt_reg) begin
                           FLASH_ADDR <= port_flash_address_reg[FLASH_ADDR_BITS-1:0];
                           FLASH_READ <= 1'b1;
                           flash_capture_reg <= 1'b1;
                           state_reg <= ST_FLASH_WAIT;
                        end
                     end
                     CMD_PC_FLASH_READ: begin
                        if (halt_reg) begin
                           FLASH_ADDR <= CPU_PC[FLASH_ADDR_BITS-1:0];
                           FLASH_READ <= 1'b1;
                           flash_capture_reg <= 1'b1;
                           state_reg <= ST_FLASH_WAIT;
                        end
                     end
                     CMD_PAGE_ERASE: begin
                        if (halt_reg) begin
                           FLASH_ADDR <= {port_flash_address_reg[FLASH_ADDR_BITS-1:FLASH_PAGE_LSB],
                                          FLASH_PAGE_LSB'(0)};
                           FLASH_PAGE_ERASE <= 1'b1;
                           flash_capture_reg <= 1'b0;
                           state_reg <= ST_FLASH_WAIT;
                        end
                     end
                     CMD_PART_ERASE: begin
                        if (halt_reg) begin
                           FLASH_PART_ERASE <= 1'b1;
                           flash_capture_reg <= 1'b0;
                           state_reg <= ST_FLASH_WAIT;
                        end
                     end
                     default: state_reg <= ST_IDLE;
                  endcase
               end
            end
            ST_PORT_WRITE: begin
               if (!CPU_PORT_BUSY) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_PORT_READ: begin
               if (!CPU_PORT_BUSY) begin
                  state_reg <= ST_PORT_CAPTURE;
               end
            end
            ST_PORT_CAPTURE: state_reg <= ST_IDLE;
            ST_FLASH_WAIT: begin
               if (FLASH_DONE) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Holding register: command results win over a nibble write in the same cycle,
   // since the host cannot see a result it has just overwritten anyway.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         data_holding_reg <= HOLD_RESET;
      end else if (state_reg == ST_PORT_CAPTURE) begin
         data_holding_reg <= PORT_RDATA;
      end else if (state_reg == ST_FLASH_WAIT && FLASH_DONE && flash_capture_reg) begin
         data_holding_reg[BYTE_BITS-1:0] <= FLASH_RDATA;
      end else if (start_reg && state_reg == ST_IDLE && halt_reg && cmd == CMD_ACC_READ) begin
         data_holding_reg <= CPU_ACC;
      end else if (start_reg && state_reg == ST_IDLE && halt_reg && cmd == CMD_PC_READ) begin
         data_holding_reg <= CPU_PC;
      end else if (link.nib_wr && in_range(link.nib_addr, NIB_HOLD_LOW, NIB_HOLD_HIGH)) begin
         data_holding_reg <= put_nibble(data_holding_reg, link.nib_addr[1:0], link.nib_val);
      end
   end
endmodule // debug_command_decoder

// ==== verilog/debug_decoder_pkg.sv ====
// Constants, command codes and widths shared by the serial debug command decoder.
// Assumes a single clock domain; the link clock is sampled, not used as a clock.
package debug_decoder_pkg;

   localparam int WORD_BITS = 16;
   localparam int NIBBLE_BITS = 4;
   localparam int FLASH_ADDR_BITS = 12;
   localparam int FLASH_PAGE_LSB = 6;
   localparam int BYTE_BITS = 8;
   localparam int PORT_SEL_BITS = 4;

   // Serial framing: an address nibble then a value nibble, both sent low bit first.
   localparam int FRAME_BITS = 8;
   localparam int ADDR_PHASE_BITS = 4;
   localparam int READOUT_BITS = 16;
   localparam int BIT_COUNT_BITS = 5;

   // Internal nibble addresses.
   localparam logic [3:0] NIB_HOLD_LOW = 4'h0;
   localparam logic [3:0] NIB_HOLD_HIGH = 4'h3;
   localparam logic [3:0] NIB_ADDR_LOW = 4'h4;
   localparam logic [3:0] NIB_ADDR_HIGH = 4'h7;
   localparam logic [3:0] NIB_COMMAND = 4'h8;
   localparam logic [3:0] NIB_MODE = 4'h9;
   localparam logic [3:0] NIB_READOUT = 4'hF;

   // Interface wiring modes.
   localparam logic [3:0] MODE_FOUR_WIRE = 4'h0;
   localparam logic [3:0] MODE_THREE_WIRE = 4'h1;

   // Reset values.
   localparam logic [15:0] HOLD_RESET = 16'h0000;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [3:0] COMMAND_RESET = 4'hC;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic HALT_RESET = 1'b0;

   typedef enum logic [3:0] {
      CMD_PORT_WRITE, CMD_FLASH_WRITE, CMD_PORT_READ, CMD_FLASH_READ,
      CMD_ACC_READ, CMD_PC_FLASH_READ, CMD_PC_READ, CMD_HALT,
      CMD_START, CMD_STEP, CMD_PC_ZERO, CMD_MODULE_RESET,
      CMD_NOP, CMD_PAGE_ERASE, CMD_PART_ERASE, CMD_AUX_PARTITION
   } command_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PORT_WRITE, ST_PORT_READ, ST_PORT_CAPTURE, ST_FLASH_WAIT
   } exec_state_type;

endpackage

// ==== verilog/frame_receiver.sv ====
// Turns sampled link edges into nibble writes and shifts the holding register out on readout.
// Assumes sampled select, clock and data levels from pin_sampler instances.
module frame_receiver
   import debug_decoder_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sel_active,
   input wire logic sclk_rise,
   input wire logic sclk_fall,
   input wire logic sdi,
   nibble_link_if.receiver link,
   output logic sdo,
   output logic sdo_oe
);
   logic [FRAME_BITS-1:0] shift_reg;
   logic [FRAME_BITS-1:0] shift_next;
   logic [BIT_COUNT_BITS-1:0] count_reg;
   logic [READOUT_BITS-1:0] out_reg;
   logic readout_reg;

   assign shift_next = {sdi, shift_reg[FRAME_BITS-1:1]};
   assign link.readout_active = readout_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= '0;
         count_reg <= '0;
         readout_reg <= 1'b0;
         out_reg <= '0;
         link.nib_wr <= 1'b0;
         link.nib_addr <= '0;
         link.nib_val <= '0;
      end else begin
         link.nib_wr <= 1'b0;
         if (!sel_active) begin
            count_reg <= '0;
            readout_reg <= 1'b0;
         end else if (readout_reg) begin
            if (sclk_fall) begin
               out_reg <= {1'b0, out_reg[READOUT_BITS-1:1]};
               count_reg <= count_reg + 1'b1;
               if (count_reg == BIT_COUNT_BITS'(READOUT_BITS - 1)) begin
                  readout_reg <= 1'b0;
                  count_reg <= '0;
               end
            end
         end else if (sclk_rise) begin
            shift_reg <= shift_next;
            count_reg <= count_reg + 1'b1;
            if (count_reg == BIT_COUNT_BITS'(ADDR_PHASE_BITS - 1) && shift_next[7:4] == NIB_READOUT) begin
               readout_reg <= 1'b1;
               out_reg <= link.readout;
               count_reg <= '0;
            end else if (count_reg == BIT_COUNT_BITS'(FRAME_BITS - 1)) begin
               link.nib_wr <= 1'b1;
               link.nib_addr <= shift_next[3:0];
               link.nib_val <= shift_next[7:4];
               count_reg <= '0;
            end
         end
      end
   end

   // Output wiring mode.
   // In 3-wire mode the line is released except while data is shifted out.
   assign sdo = out_reg[0];
   assign sdo_oe = sel_active && (link.four_wire || readout_reg);
endmodule // frame_receiver

// ==== verilog/nibble_link_if.sv ====
// Carries decoded nibble writes and readout data between the frame receiver and the decoder core.
// Assumes both ends run on the same system clock.
interface nibble_link_if;
   logic nib_wr;
   logic [3:0] nib_addr;
   logic [3:0] nib_val;
   logic readout_active;
   logic [15:0] readout;
   logic four_wire;

   modport receiver (output nib_wr, nib_addr, nib_val, readout_active, input readout, four_wire);
   modport core (input nib_wr, nib_addr, nib_val, readout_active, output readout, four_wire);
endinterface

// ==== verilog/pin_sampler.sv ====
// Three-stage sampler for a pin from outside the clock domain, with edge pulses.
// Assumes the pin is slow against the system clock (at least a few clocks per level).
module pin_sampler (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_reg, s2_reg, s3_reg;

   // The first stage feeds only the second, so a metastable value never reaches logic.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change only counts once the second and third stages agree.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         rise <= (s2_reg == s3_reg) && s3_reg && !level;
         fall <= (s2_reg == s3_reg) && !s3_reg && level;
         if (s2_reg == s3_reg) begin
            level <= s3_reg;
         end
      end
   end
endmodule // pin_sampler
